// ===== shared/ssx_defines.vh
`ifndef SSX_DEFINES_VH
`define SSX_DEFINES_VH
`define SSX_OP_SPECIAL 6'h00
`define SSX_OP_SYSCTL 6'h10
`define SSX_OP_STORE_WORD 6'h2B
`define SSX_OP_STORE_LEFT 6'h2A
`define SSX_FN_SRL_IMM 6'h02
`define SSX_FN_SRL_VAR 6'h06
`define SSX_FN_SUB_TRAP 6'h22
`define SSX_FN_SUB_NOTRAP 6'h23
`define SSX_FN_LIGHT_SLEEP 6'h21
`define SSX_FN_DEEP_SLEEP 6'h22
`define SSX_ZERO5 5'h00
`define SSX_LEM_OFS_HI 3'h4
`define SSX_LEM_OFS_LO 3'h0
`define SSX_EXC_NONE 3'h0
`define SSX_EXC_OVF 3'h1
`define SSX_EXC_ADDR 3'h2
`define SSX_EXC_CPU 3'h3
`define SSX_EXC_RSVD 3'h4
`define SSX_ADDR_IDX_MASK 3'h0
`define SSX_ADDR_IRQ_STAT 3'h1
`define SSX_ADDR_IRQ_CLR 3'h2
`define SSX_ADDR_IRQ_EN 3'h3
`define SSX_ADDR_MODE 3'h4
`define SSX_IRQ_BITS 4
`define SSX_IRQ_OVF 0
`define SSX_IRQ_ADDR 1
`define SSX_IRQ_CPU 2
`define SSX_IRQ_WAKE 3
`endif

// ===== rtl/ssx_exec.v
`timescale 1ns/1ns
`include "ssx_defines.vh"

module ssx_exec (
    input wire i_clk_sys,
    input wire i_arst_n,
    input wire i_instr_valid,
    input wire [31:0] i_instr,
    input wire [63:0] i_src_a,
    input wire [63:0] i_src_b,
    input wire i_mode64,
    input wire i_system_control_major_op_usable,
    input wire [31:0] i_paddr,
    input wire i_user_byte_order_flip,
    input wire i_memory_big_order_flag,
    input wire i_processor_big_order_flag,
    input wire i_wb_done,
    input wire i_bus_idle,
    input wire i_irq,
    input wire i_nmi,
    input wire i_soft_reset,
    input wire i_cold_reset,
    input wire [2:0] i_reg_addr,
    input wire [31:0] i_reg_wdata,
    input wire i_reg_wr,
    input wire i_reg_rd,
    output reg o_wr_en,
    output reg [4:0] o_wr_dest,
    output reg [63:0] o_wr_data,
    output reg [2:0] o_exc_code,
    output reg o_exc_valid,
    output reg o_store_valid,
    output reg [63:0] o_store_vaddr,
    output reg [31:0] o_store_paddr,
    output reg [63:0] o_store_data,
    output reg [1:0] o_store_type,
    output reg o_core_clk_en,
    output reg o_bus_clk_en,
    output reg [31:0] o_reg_rdata,
    output reg o_irq
);

    localparam [3:0] ST_RUN = 4'h1;
    localparam [3:0] ST_WAIT = 4'h2;
    localparam [3:0] ST_STANDBY = 4'h4;
    localparam [3:0] ST_SUSPEND = 4'h8;

    wire [5:0] op = i_instr[31:26];
    wire [4:0] f_rs = i_instr[25:21];
    wire [4:0] f_rt = i_instr[20:16];
    wire [4:0] f_rd = i_instr[15:11];
    wire [4:0] f_sa = i_instr[10:6];
    wire [5:0] fn = i_instr[5:0];
    wire [63:0] off_sx = {{48{i_instr[15]}}, i_instr[15:0]};

    // Shared by both right shifts and the subtracts
    function [63:0] sx32;
        input [31:0] v;
        input m64;
        begin
            sx32 = m64 ? {{32{v[31]}}, v} : {32'h0000_0000, v};
        end
    endfunction

    // Synchronised wake sources, pins from outside this clock
    reg [3:0] wake_s1_reg;
    reg [3:0] wake_s2_reg;
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wake_s1_reg <= 4'h0;
            wake_s2_reg <= 4'h0;
        end else begin
            wake_s1_reg <= {i_irq, i_nmi, i_soft_reset, i_cold_reset};
            wake_s2_reg <= wake_s1_reg;
        end
    end
    wire wake = |wake_s2_reg;

    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg deep_reg;
    reg deep_next;

    // Decode
    wire is_special = (op == `SSX_OP_SPECIAL);
    wire is_srl = is_special && (fn == `SSX_FN_SRL_IMM) && (f_rs == `SSX_ZERO5);
    wire is_shift_right_logical_var = is_special && (fn == `SSX_FN_SRL_VAR) && (f_sa == `SSX_ZERO5);
    wire is_sub = is_special && (fn == `SSX_FN_SUB_TRAP) && (f_sa == `SSX_ZERO5);
    wire is_minus_no_trap = is_special && (fn == `SSX_FN_SUB_NOTRAP) && (f_sa == `SSX_ZERO5);
    wire is_sys = (op == `SSX_OP_SYSCTL) && i_instr[25];
    wire is_light = is_sys && (fn == `SSX_FN_LIGHT_SLEEP);
    wire is_deep = is_sys && (fn == `SSX_FN_DEEP_SLEEP);
    wire is_sw = (op == `SSX_OP_STORE_WORD);
    wire is_swl = (op == `SSX_OP_STORE_LEFT);

    // Arithmetic
    wire [4:0] sh_amt = is_shift_right_logical_var ? i_src_a[4:0] : f_sa;
    wire [31:0] sh_res = i_src_b[31:0] >> sh_amt;
    wire [31:0] diff = i_src_a[31:0] - i_src_b[31:0];
    wire [31:0] nb = ~i_src_b[31:0];
    wire [31:0] low_sum = {1'b0, i_src_a[30:0]} + {1'b0, nb[30:0]} + 32'h0000_0001;
    wire c30 = low_sum[31];
    wire c31 = (i_src_a[31] & nb[31]) | (c30 & (i_src_a[31] ^ nb[31]));
    wire ovf = c30 ^ c31;

    // Stores
    wire [63:0] vaddr = i_src_a + off_sx;
    wire [1:0] byte_idx = vaddr[1:0] ^ {2{i_processor_big_order_flag}};
    wire [2:0] pa_flip = i_paddr[2:0] ^ {3{i_user_byte_order_flip}};
    wire [1:0] pa_low = i_memory_big_order_flag ? pa_flip[1:0] : 2'h0;
    wire hi_word = vaddr[2] ^ i_processor_big_order_flag;
    wire [4:0] swl_sh = {~byte_idx, 3'h0};
    wire [31:0] swl_word = i_src_b[31:0] >> swl_sh;

    // Status, enable registers
    reg [`SSX_IRQ_BITS-1:0] stat_reg;
    reg [`SSX_IRQ_BITS-1:0] en_reg;
    reg [`SSX_IRQ_BITS-1:0] evt;
    wire run = (state_reg == ST_RUN);
    wire fire = i_instr_valid && run;

    always @* begin
        evt = {`SSX_IRQ_BITS{1'b0}};
        if (fire && is_sub && ovf) begin
            evt[`SSX_IRQ_OVF] = 1'b1;
        end
        if (fire && is_sw && (vaddr[1:0] != 2'h0)) begin
            evt[`SSX_IRQ_ADDR] = 1'b1;
        end
        if (fire && (is_light || is_deep) && !i_system_control_major_op_usable) begin
            evt[`SSX_IRQ_CPU] = 1'b1;
        end
        if ((state_reg == ST_STANDBY || state_reg == ST_SUSPEND) && wake) begin
            evt[`SSX_IRQ_WAKE] = 1'b1;
        end
    end

    always @* begin
        state_next = state_reg;
        deep_next = deep_reg;
        case (state_reg)
            ST_RUN: begin
                if (fire && (is_light || is_deep) && i_system_control_major_op_usable) begin
                    state_next = ST_WAIT;
                    deep_next = is_deep;
                end
            end
            ST_WAIT: begin
                // Wait for writeback to finish and bus to drain
                if (wake) begin
                    state_next = ST_RUN;
                end else if (i_wb_done && i_bus_idle) begin
                    state_next = deep_reg ? ST_SUSPEND : ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                if (wake) begin
                    state_next = ST_RUN;
                end
            end
            ST_SUSPEND: begin
                if (wake) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg <= ST_RUN;
            deep_reg <= 1'b0;
            o_core_clk_en <= 1'b1;
            o_bus_clk_en <= 1'b1;
        end else begin
            state_reg <= state_next;
            deep_reg <= deep_next;
            // Only core gated in standby; bus clock too in suspend
            o_core_clk_en <= !(state_next == ST_STANDBY || state_next == ST_SUSPEND);
            o_bus_clk_en <= (state_next != ST_SUSPEND);
        end
    end

    // Execute
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_wr_en <= 1'b0;
            o_wr_dest <= 5'h00;
            o_wr_data <= 64'h0000_0000_0000_0000;
            o_exc_valid <= 1'b0;
            o_exc_code <= `SSX_EXC_NONE;
            o_store_valid <= 1'b0;
            o_store_vaddr <= 64'h0000_0000_0000_0000;
            o_store_paddr <= 32'h0000_0000;
            o_store_data <= 64'h0000_0000_0000_0000;
            o_store_type <= 2'h0;
        end else begin
            o_wr_en <= 1'b0;
            o_exc_valid <= 1'b0;
            o_exc_code <= `SSX_EXC_NONE;
            o_store_valid <= 1'b0;
            if (fire) begin
                if (is_srl || is_shift_right_logical_var) begin
                    o_wr_en <= 1'b1;
                    o_wr_dest <= f_rd;
                    o_wr_data <= sx32(sh_res, i_mode64);
                end else if (is_sub) begin
                    if (ovf) begin
                        o_exc_valid <= 1'b1;
                        o_exc_code <= `SSX_EXC_OVF;
                    end else begin
                        o_wr_en <= 1'b1;
                        o_wr_dest <= f_rd;
                        o_wr_data <= sx32(diff, i_mode64);
                    end
                end else if (is_minus_no_trap) begin
                    o_wr_en <= 1'b1;
                    o_wr_dest <= f_rd;
                    o_wr_data <= sx32(diff, i_mode64);
                end else if (is_sw) begin
                    if (vaddr[1:0] != 2'h0) begin
                        o_exc_valid <= 1'b1;
                        o_exc_code <= `SSX_EXC_ADDR;
                    end else begin
                        o_store_valid <= 1'b1;
                        o_store_vaddr <= vaddr;
                        o_store_paddr <= i_paddr;
                        o_store_type <= 2'h3;
                        o_store_data <= vaddr[2] ? {i_src_b[31:0], 32'h0000_0000}
                                                 : {32'h0000_0000, i_src_b[31:0]};
                    end
                end else if (is_swl) begin
                    // No alignment check at all here
                    o_store_valid <= 1'b1;
                    o_store_vaddr <= vaddr;
                    o_store_type <= byte_idx;
                    o_store_paddr <= {i_paddr[31:3], pa_flip[2], pa_low};
                    o_store_data <= hi_word ? {swl_word, 32'h0000_0000}
                                            : {32'h0000_0000, swl_word};
                end else if ((is_light || is_deep) && !i_system_control_major_op_usable) begin
                    o_exc_valid <= 1'b1;
                    o_exc_code <= `SSX_EXC_CPU;
                end else if (!(is_light || is_deep)) begin
                    o_exc_valid <= 1'b1;
                    o_exc_code <= `SSX_EXC_RSVD;
                end
            end
        end
    end

    // Register port; set beats clear so no event is lost
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            stat_reg <= {`SSX_IRQ_BITS{1'b0}};
            en_reg <= {`SSX_IRQ_BITS{1'b0}};
            o_reg_rdata <= 32'h0000_0000;
            o_irq <= 1'b0;
        end else begin
            if (i_reg_wr && i_reg_addr == `SSX_ADDR_IRQ_CLR) begin
                stat_reg <= (stat_reg & ~i_reg_wdata[`SSX_IRQ_BITS-1:0]) | evt;
            end else begin
                stat_reg <= stat_reg | evt;
            end
            if (i_reg_wr && i_reg_addr == `SSX_ADDR_IRQ_EN) begin
                en_reg <= i_reg_wdata[`SSX_IRQ_BITS-1:0];
            end
            o_irq <= |((stat_reg | evt) & en_reg);
            o_reg_rdata <= 32'h0000_0000;
            if (i_reg_rd) begin
                if (i_reg_addr == `SSX_ADDR_IRQ_STAT) begin
                    o_reg_rdata <= {28'h000_0000, stat_reg};
                end else if (i_reg_addr == `SSX_ADDR_IRQ_EN) begin
                    o_reg_rdata <= {28'h000_0000, en_reg};
                end else if (i_reg_addr == `SSX_ADDR_MODE) begin
                    o_reg_rdata <= {27'h000_0000, deep_reg, state_reg};
                end
            end
        end
    end

endmodule

// ===== verif/ssx_exec_monitor.sv
`timescale 1ns/1ns
`include "ssx_defines.vh"
module ssx_exec_monitor (
    input wire i_clk_sys,
    input wire i_arst_n,
    input wire i_instr_valid,
    input wire [31:0] i_instr,
    input wire [63:0] i_src_a,
    input wire [63:0] i_src_b,
    input wire i_mode64,
    input wire i_bus_idle,
    input wire i_irq,
    input wire o_wr_en,
    input wire [63:0] o_wr_data,
    input wire [2:0] o_exc_code,
    input wire o_exc_valid,
    input wire o_store_valid,
    input wire [63:0] o_store_vaddr,
    input wire o_core_clk_en,
    input wire o_bus_clk_en
);
    reg pv_reg;
    reg pm_reg;
    reg [31:0] pi_reg;
    reg [63:0] pa_reg;
    reg [63:0] pb_reg;
    // Request taken at the last edge, so each answer is judged against its cause
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pv_reg <= 1'h0;
        end else begin
            pv_reg <= i_instr_valid;
        end
    end
    always @(posedge i_clk_sys) begin
        pm_reg <= i_mode64;
        pi_reg <= i_instr;
        pa_reg <= i_src_a;
        pb_reg <= i_src_b;
    end
    wire sp = pv_reg && pi_reg[31:26] == `SSX_OP_SPECIAL;
    wire [31:0] df = pa_reg[31:0] - pb_reg[31:0];
    wire [31:0] si = pb_reg[31:0] >> pi_reg[10:6];
    wire [31:0] sv = pb_reg[31:0] >> pa_reg[4:0];
    wire ovf = (pa_reg[31] != pb_reg[31]) && (df[31] != pa_reg[31]);
    wire [31:0] va = pa_reg[31:0] + {{16{pi_reg[15]}}, pi_reg[15:0]};
    default clocking @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_arst_n);
    property p_srl_imm;
        o_wr_en && sp && pi_reg[5:0] == 6'h02 && pm_reg |-> o_wr_data == {{32{si[31]}}, si};
    endproperty
    a_srl_imm: assert property (p_srl_imm) else $error("shift imm wrong");
    property p_srl_var;
        o_wr_en && sp && pi_reg[5:0] == 6'h06 && pm_reg |-> o_wr_data == {{32{sv[31]}}, sv};
    endproperty
    a_srl_var: assert property (p_srl_var) else $error("shift var wrong");
    property p_ovf;
        sp && pi_reg[5:0] == 6'h22 && ovf |-> o_exc_valid && o_exc_code == 3'h1 && !o_wr_en;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not trapped");
    property p_minus_no_trap;
        sp && pi_reg[5:0] == 6'h23 && pm_reg |-> o_wr_en && !o_exc_valid && o_wr_data == {{32{df[31]}}, df};
    endproperty
    a_minus_no_trap: assert property (p_minus_no_trap) else $error("subtract wrong");
    property p_sw;
        pv_reg && pi_reg[31:26] == 6'h2B |-> if (va[1:0] != 2'h0) (o_exc_valid && !o_store_valid)
            else (o_store_valid && o_store_vaddr[31:0] == va);
    endproperty
    a_sw: assert property (p_sw) else $error("word store wrong");
    property p_swl;
        pv_reg && pi_reg[31:26] == 6'h2A |-> o_store_valid && !o_exc_valid;
    endproperty
    a_swl: assert property (p_swl) else $error("left store refused");
    property p_gate;
        $fell(o_core_clk_en) |-> $past(i_bus_idle);
    endproperty
    a_gate: assert property (p_gate) else $error("clocks stopped on busy bus");
    property p_wake;
        !o_core_clk_en && i_irq |-> ##[1:5] o_core_clk_en && o_bus_clk_en;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    c_ovf: cover property (o_exc_valid && o_exc_code == 3'h1);
    c_stby: cover property ($fell(o_core_clk_en) && o_bus_clk_en);
    c_deep: cover property ($fell(o_bus_clk_en));
endmodule
bind ssx_exec ssx_exec_monitor u_mon (.*);

// ===== verif/ssx_mem_model.sv
`timescale 1ns/1ns
module ssx_mem_model (
    input wire i_clk_sys,
    input wire i_arst_n,
    input wire i_store_valid,
    input wire i_slow,
    output wire o_bus_idle
);
    reg [3:0] busy_reg;
    assign o_bus_idle = busy_reg == 4'h0;
    // Slow mode keeps the bus busy long enough to hold off a sleep request
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            busy_reg <= 4'h0;
        end else if (i_store_valid) begin
            busy_reg <= i_slow ? 4'h9 : 4'h1;
        end else if (busy_reg != 4'h0) begin
            busy_reg <= busy_reg - 4'h1;
        end
    end
endmodule

// ===== verif/tb_ssx_exec.sv
`timescale 1ns/1ns
`include "ssx_defines.vh"
module tb_ssx_exec;
    reg i_clk_sys = 1'h0, i_arst_n = 1'h0, i_instr_valid = 1'h0, i_mode64 = 1'h1, slow = 1'h0;
    reg i_system_control_major_op_usable = 1'h0, i_wb_done = 1'h0, i_irq = 1'h0, i_nmi = 1'h0, i_reg_wr = 1'h0;
    reg i_soft_reset = 1'h0, i_cold_reset = 1'h0, i_reg_rd = 1'h0, i_user_byte_order_flip = 1'h0;
    reg i_memory_big_order_flag = 1'h0, i_processor_big_order_flag = 1'h0;
    reg [31:0] i_instr = 32'h0, i_paddr = 32'h0, i_reg_wdata = 32'h0, w;
    reg [63:0] i_src_a = 64'h0, i_src_b = 64'h0;
    reg [2:0] i_reg_addr = 3'h0;
    wire i_bus_idle, o_wr_en, o_exc_valid, o_store_valid, o_core_clk_en, o_bus_clk_en, o_irq;
    wire [4:0] o_wr_dest;
    wire [63:0] o_wr_data, o_store_vaddr, o_store_data;
    wire [31:0] o_store_paddr, o_reg_rdata;
    wire [2:0] o_exc_code;
    wire [1:0] o_store_type;
    integer n_fail = 0, num_checks = 0, cyc = 0, k, n;
    ssx_exec uut (.*);
    ssx_mem_model mem (.i_clk_sys, .i_arst_n, .i_store_valid(o_store_valid), .i_slow(slow),
        .o_bus_idle(i_bus_idle));
    initial forever #50 i_clk_sys = ~i_clk_sys;
    task chk(input [63:0] nm, input [127:0] e, input [127:0] g);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("Error %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task exec(input [31:0] ins, input [63:0] a, input [63:0] b, input [31:0] p);
        begin
            @(posedge i_clk_sys);
            i_instr_valid <= 1'h1;
            i_instr <= ins;
            i_src_a <= a;
            i_src_b <= b;
            i_paddr <= p;
            @(posedge i_clk_sys);
            i_instr_valid <= 1'h0;
            #1;
        end
    endtask
    task rg(input wr, input [2:0] ad, input [31:0] d);
        begin
            @(posedge i_clk_sys);
            i_reg_wr <= wr;
            i_reg_rd <= !wr;
            i_reg_addr <= ad;
            i_reg_wdata <= d;
            @(posedge i_clk_sys);
            i_reg_wr <= 1'h0;
            i_reg_rd <= 1'h0;
            #1;
        end
    endtask
    task wait_en(input e);
        for (n = 0; n < 40 && o_core_clk_en !== e; n = n + 1) begin
            @(posedge i_clk_sys);
            #1;
        end
    endtask
    function [63:0] sx(input [31:0] x);
        sx = {{32{x[31]}}, x};
    endfunction
    function [31:0] rop(input [5:0] f);
        rop = {6'h00, 5'h1, 5'h2, 5'h3, 5'h0, f};
    endfunction
    task end_of_test;
        begin
            if (n_fail == 0 && num_checks > 0) begin
                $display("RESULT: PASS");
            end else begin
                $display("RESULT: FAIL");
            end
            $finish;
        end
    endtask
    always @(posedge i_clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            end_of_test;
        end
    end
    initial begin
        repeat (3) @(posedge i_clk_sys);
        i_arst_n <= 1'h1;
        rg(0, `SSX_ADDR_MODE, 0);
        chk("mode", 32'h1, o_reg_rdata);
        rg(0, `SSX_ADDR_IDX_MASK, 0);
        chk("unmapped", 32'h0, o_reg_rdata);
        rg(1, `SSX_ADDR_IRQ_EN, 32'hF);
        for (k = 0; k < 32; k = k + 1) begin
            exec({11'h0, 5'h2, 5'h3, k[4:0], 6'h02}, 0, 64'hFFFFFFFF80A5C3E1, 0);
            chk("srl_imm", {1'h1, 5'h3, sx(32'h80A5C3E1 >> k)}, {o_wr_en, o_wr_dest, o_wr_data});
            exec(rop(6'h06), {32'h0, 27'h5A5, k[4:0]}, 64'h7F00FF01, 0);
            chk("srl_var", sx(32'h7F00FF01 >> k), o_wr_data);
        end
        i_mode64 <= 1'h0;
        exec({11'h0, 5'h2, 5'h3, 5'h4, 6'h02}, 0, 64'h80A5C3E1, 0);
        chk("srl32", 32'h080A5C3E, o_wr_data[31:0]);
        i_mode64 <= 1'h1;
        exec(rop(6'h22), 64'h7FFFFFFF, 64'hFFFFFFFFFFFFFFFF, 0);
        chk("ovf", {2'h1, `SSX_EXC_OVF}, {o_wr_en, o_exc_valid, o_exc_code});
        exec(rop(6'h22), 64'h5, 64'h7, 0);
        chk("sub", {2'h2, 64'hFFFFFFFFFFFFFFFE}, {o_wr_en, o_exc_valid, o_wr_data});
        exec(rop(6'h23), 64'h7FFFFFFF, 64'hFFFFFFFFFFFFFFFF, 0);
        chk("minus_no_trap", {2'h2, 64'hFFFFFFFF80000000}, {o_wr_en, o_exc_valid, o_wr_data});
        rg(0, `SSX_ADDR_IRQ_STAT, 0);
        chk("stat", 33'h100000001, {o_irq, o_reg_rdata});
        rg(1, `SSX_ADDR_IRQ_CLR, 32'hF);
        rg(1, `SSX_ADDR_IRQ_EN, 32'h0);
        exec({6'h2B, 5'h1, 5'h2, 16'hFFFC}, 64'h1000, 64'hCAFE0123, 32'hFFC);
        chk("sw", {3'h7, 64'hFFC, 32'hCAFE0123}, {o_store_valid, o_store_type, o_store_vaddr,
            o_store_data[63:32]});
        exec({6'h2B, 5'h1, 5'h2, 16'h0001}, 64'h1000, 64'h0, 0);
        chk("sw_err", {2'h1, `SSX_EXC_ADDR}, {o_store_valid, o_exc_valid, o_exc_code});
        rg(0, `SSX_ADDR_IRQ_STAT, 0);
        chk("masked", 33'h2, {o_irq, o_reg_rdata});
        for (k = 0; k < 9; k = k + 1) begin
            i_user_byte_order_flip <= k == 8;
            exec({6'h2A, 5'h1, 5'h2, 13'h0, k[2:0]}, 64'h2000, 64'h11223344, 32'h80002000 + k);
            w = 32'h11223344 >> (24 - 8 * k[1:0]);
            chk("swl", {2'h2, k[1:0], k[2] ? {w, 32'h0} : {32'h0, w}}, {o_store_valid, o_exc_valid,
                o_store_type, o_store_data});
            chk("swl_pa", 32'h80002000 + (k & 8) + ((k & 4) ^ (k == 8 ? 4 : 0)), o_store_paddr);
        end
        i_user_byte_order_flip <= 1'h0;
        exec(32'hFC00_0000, 0, 0, 0);
        chk("rsvd", {2'h1, `SSX_EXC_RSVD}, {o_wr_en, o_exc_valid, o_exc_code});
        exec({6'h10, 1'h1, 19'h0, 6'h21}, 0, 0, 0);
        chk("cpu", {2'h3, `SSX_EXC_CPU}, {o_core_clk_en, o_exc_valid, o_exc_code});
        i_system_control_major_op_usable <= 1'h1;
        slow <= 1'h1;
        for (k = 0; k < 2; k = k + 1) begin
            exec({6'h2B, 5'h1, 5'h2, 16'h0}, 64'h1000, 0, 0);
            exec({6'h10, 1'h1, 19'h0, k ? 6'h22 : 6'h21}, 0, 0, 0);
            i_wb_done <= 1'h1;
            chk("hold", 1'h1, o_core_clk_en);
            wait_en(0);
            rg(0, `SSX_ADDR_MODE, 0);
            chk("sleep", {k == 0, k ? 32'h18 : 32'h4}, {o_bus_clk_en, o_reg_rdata});
            i_irq <= 1'h1;
            wait_en(1);
            #1;
            chk("wake", 2'h3, {o_core_clk_en, o_bus_clk_en});
            i_irq <= 1'h0;
            i_wb_done <= 1'h0;
            repeat (4) @(posedge i_clk_sys);
        end
        end_of_test;
    end
endmodule
